// [core/btc_regs.sv]
// block transfer control register bank behind an axi4-lite slave
`timescale 1ns/10ps
module btc_regs (
  // clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // axi4-lite write address
  input  wire logic                          i_awvalid,
  output      logic                          o_awready,
  input  wire logic [btc_pkg::BTC_ADDR_W-1:0] i_awaddr,
  input  wire logic [2:0]                    i_awprot,
  // axi4-lite write data
  input  wire logic                          i_wvalid,
  output      logic                          o_wready,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic [3:0]                    i_wstrb,
  // axi4-lite write response
  output      logic                          o_bvalid,
  input  wire logic                          i_bready,
  output      logic [1:0]                    o_bresp,
  // axi4-lite read address
  input  wire logic                          i_arvalid,
  output      logic                          o_arready,
  input  wire logic [btc_pkg::BTC_ADDR_W-1:0] i_araddr,
  input  wire logic [2:0]                    i_arprot,
  // axi4-lite read data
  output      logic                          o_rvalid,
  input  wire logic                          i_rready,
  output      logic [31:0]                   o_rdata,
  output      logic [1:0]                    o_rresp,
  // transfer datapath side
  output      logic                          o_start,
  output      logic                          o_busy,
  input  wire logic                          i_done,
  output      btc_pkg::btc_cfg_t             o_cfg
);

  // present and next state
  btc_pkg::btc_state_t st_reg;
  btc_pkg::btc_state_t st_next;

  // channel handshakes in this cycle
  logic aw_now;
  logic w_now;
  logic ar_now;

  // write decode
  logic                          have_aw;
  logic                          have_w;
  logic [btc_pkg::BTC_IDX_W-1:0] wr_idx;
  logic [btc_pkg::BTC_IDX_W-1:0] wr_off;
  logic                          wr_hit;
  logic [3:0]                    wr_ent;
  logic [7:0]                    wr_byte;
  logic                          wr_lane;
  logic [7:0]                    wr_mask;

  // read decode
  logic [btc_pkg::BTC_IDX_W-1:0] rd_idx;
  logic [btc_pkg::BTC_IDX_W-1:0] rd_off;
  logic                          rd_hit;
  logic [3:0]                    rd_ent;
  logic [7:0]                    rd_byte;

  // start request seen in this cycle
  logic start_req;

  // prot carries nothing for this bank
  logic unused_prot;
  assign unused_prot = ^{i_awprot, i_arprot, i_wstrb[3:1],
                         i_wdata[31:8]};

  // ready while nothing of that channel is held and no answer waits (write response for aw and w, read data for ar)
  assign o_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign o_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign o_arready = !st_reg.rvalid;

  // handshake terms
  assign aw_now = i_awvalid && o_awready;
  assign w_now  = i_wvalid && o_wready;
  assign ar_now = i_arvalid && o_arready;

  // address or data either held or arriving now
  assign have_aw = st_reg.aw_got || aw_now;
  assign have_w  = st_reg.w_got || w_now;

  // write target from held or live address
  assign wr_idx = st_reg.aw_got ? st_reg.aw_idx
                : i_awaddr[btc_pkg::BTC_IDX_W+1:2];
  assign wr_off = btc_pkg::BTC_IDX_W'(wr_idx - btc_pkg::BTC_IDX_CTRL0);
  assign wr_hit = (wr_idx >= btc_pkg::BTC_IDX_CTRL0)
               && (wr_idx <= btc_pkg::BTC_IDX_HH);
  assign wr_ent = wr_off[3:0];

  // write data from held or live beat, low lane only
  assign wr_byte = st_reg.w_got ? st_reg.w_byte : i_wdata[7:0];
  assign wr_lane = st_reg.w_got ? st_reg.w_lane : i_wstrb[0];
  assign wr_mask = btc_pkg::BTC_WMASK[wr_ent];

  // read target
  assign rd_idx = i_araddr[btc_pkg::BTC_IDX_W+1:2];
  assign rd_off = btc_pkg::BTC_IDX_W'(rd_idx - btc_pkg::BTC_IDX_CTRL0);
  assign rd_hit = (rd_idx >= btc_pkg::BTC_IDX_CTRL0)
               && (rd_idx <= btc_pkg::BTC_IDX_HH);
  assign rd_ent = rd_off[3:0];

  // start request: a one in the start bit of control 0
  assign start_req = have_aw && have_w && wr_hit && wr_lane
                  && (wr_idx == btc_pkg::BTC_IDX_CTRL0)
                  && wr_byte[btc_pkg::BTC_BIT_START]; // [R1]

  // read value, busy replaces the start bit
  always_comb begin
    rd_byte = 8'h00;
    if (rd_hit) begin
      // stored bits only, unused bits stay zero
      rd_byte = st_reg.regs[rd_ent]
              & btc_pkg::BTC_WMASK[rd_ent]; // [R21]
      if (rd_idx == btc_pkg::BTC_IDX_CTRL0) begin
        rd_byte[btc_pkg::BTC_BIT_START] =
          (st_reg.eng == btc_pkg::BTC_BUSY); // [R2]
      end
    end
  end

  // next state of the whole bank
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;

    // hold an address taken ahead of its data
    if (aw_now) begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = i_awaddr[btc_pkg::BTC_IDX_W+1:2];
    end

    // hold data taken ahead of its address
    if (w_now) begin
      st_next.w_got  = 1'b1;
      st_next.w_byte = i_wdata[7:0];
      st_next.w_lane = i_wstrb[0];
    end

    // both halves present: perform the write
    if (have_aw && have_w) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_hit ? btc_pkg::BTC_RESP_OKAY
                              : btc_pkg::BTC_RESP_SLVERR;
      // masked store keeps unused bits at zero
      if (wr_hit && wr_lane) begin
        st_next.regs[wr_ent] = wr_byte & wr_mask; // [R21]
      end
    end

    // response leaves once taken
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end

    // engine: done ends a transfer
    if (i_done && st_reg.eng == btc_pkg::BTC_BUSY) begin
      st_next.eng = btc_pkg::BTC_IDLE; // [R20]
    end

    // a start while busy is dropped, even beside a done in the same cycle
    if (start_req && st_reg.eng == btc_pkg::BTC_IDLE) begin
      st_next.eng   = btc_pkg::BTC_BUSY; // [R20]
      st_next.start = 1'b1; // [R1]
    end

    // read: answer one cycle after the address
    if (ar_now) begin
      st_next.rvalid = 1'b1;
      st_next.rbyte  = rd_byte;
      st_next.rresp  = rd_hit ? btc_pkg::BTC_RESP_OKAY
                              : btc_pkg::BTC_RESP_SLVERR;
    end else if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_reg.regs   <= {btc_pkg::BTC_NREG{btc_pkg::BTC_RST_BYTE}};
      st_reg.eng    <= btc_pkg::BTC_IDLE;
      st_reg.start  <= 1'b0;
      st_reg.aw_got <= 1'b0;
      st_reg.aw_idx <= '0;
      st_reg.w_got  <= 1'b0;
      st_reg.w_byte <= 8'h00;
      st_reg.w_lane <= 1'b0;
      st_reg.bvalid <= 1'b0;
      st_reg.bresp  <= btc_pkg::BTC_RESP_OKAY;
      st_reg.rvalid <= 1'b0;
      st_reg.rbyte  <= 8'h00;
      st_reg.rresp  <= btc_pkg::BTC_RESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus answers straight from flops
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp  = st_reg.bresp;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata  = {24'h000000, st_reg.rbyte};
  assign o_rresp  = st_reg.rresp;

  // engine handshake
  assign o_start = st_reg.start;
  assign o_busy  = (st_reg.eng == btc_pkg::BTC_BUSY); // [R2]

  // byte views of the stored entries
  logic [7:0] r_ctrl0;
  logic [7:0] r_ctrl1;
  logic [7:0] r_lmode;
  logic [7:0] r_lvis;
  logic [7:0] r_sxl;
  logic [7:0] r_sxh;
  logic [7:0] r_syl;
  logic [7:0] r_syh;
  logic [7:0] r_dxl;
  logic [7:0] r_dxh;
  logic [7:0] r_dyl;
  logic [7:0] r_dyh;
  logic [7:0] r_wl;
  logic [7:0] r_wh;
  logic [7:0] r_hl;
  logic [7:0] r_hh;

  // entries laid out in index order
  assign {r_hh, r_hl, r_wh, r_wl,
          r_dyh, r_dyl, r_dxh, r_dxl,
          r_syh, r_syl, r_sxh, r_sxl,
          r_lvis, r_lmode, r_ctrl1, r_ctrl0} = st_reg.regs;

  // layout selects
  assign o_cfg.src_linear = r_ctrl0[btc_pkg::BTC_BIT_SRC_LIN]; // [R3]
  assign o_cfg.dst_linear = r_ctrl0[btc_pkg::BTC_BIT_DST_LIN]; // [R4]

  // raster and operation codes, stored as written
  assign o_cfg.rop    = r_ctrl1[7:4]; // [R5]
  assign o_cfg.opcode = r_ctrl1[3:0]; // [R6]

  // layer scroll, transparency and blend modes
  assign o_cfg.scroll_mode  = r_lmode[7:6]; // [R7]
  assign o_cfg.float_transp = r_lmode[btc_pkg::BTC_BIT_FLOAT]; // [R8]
  assign o_cfg.disp_mode    = r_lmode[2:0]; // [R9]

  // per-layer visibility in eighths
  assign o_cfg.l2_vis = r_lvis[7:4]; // [R11]
  assign o_cfg.l1_vis = r_lvis[3:0]; // [R12]

  // source point and layer
  assign o_cfg.src_x     = {r_sxh[1:0], r_sxl}; // [R13]
  assign o_cfg.src_y     = {r_syh[0], r_syl}; // [R14]
  assign o_cfg.src_layer = r_syh[btc_pkg::BTC_BIT_LAYER]; // [R15]

  // destination point and layer
  assign o_cfg.dst_x     = {r_dxh[1:0], r_dxl}; // [R16]
  assign o_cfg.dst_y     = {r_dyh[0], r_dyl}; // [R17]
  assign o_cfg.dst_layer = r_dyh[btc_pkg::BTC_BIT_LAYER]; // [R18]

  // transfer size
  assign o_cfg.width  = {r_wh[1:0], r_wl}; // [R19]
  assign o_cfg.height = {r_hh[1:0], r_hl}; // [R19]

endmodule

// [common/btc_pkg.sv]
// constants and types for the block transfer control register bank
// Operation
// R1 - writing one to start bit launches transfer
// R2 - start bit reads back the busy flag
// R3 - control 0 bit 6 selects source layout
// R4 - control 0 bit 5 selects destination layout
// R5 - control 1 high nibble holds raster code
// R6 - control 1 low nibble holds operation code
// R7 - layer mode bits 7-6 select scroll mode
// R8 - layer mode bit 5 enables window transparency
// R9 - layer mode bits 2-0 select blend mode
// R10 - host clears scroll bit before buffer scroll
// R11 - visibility high nibble sets layer 2 level
// R12 - visibility low nibble sets layer 1 level
// R13 - source x is ten bits over two
// R14 - source y is nine bits over two
// R15 - source y high bit 7 picks layer
// R16 - destination x is ten bits over two
// R17 - destination y is nine bits over two
// R18 - destination y high bit 7 picks layer
// R19 - width and height ten bits, same split
// R20 - busy holds from start until done
// R21 - unused bits read zero, ignore writes
package btc_pkg;

  // bus geometry
  localparam int BTC_ADDR_W = 9;
  localparam int BTC_IDX_W  = 7;
  localparam int BTC_NREG   = 16;

  // register indexes, byte address is four times the index
  localparam logic [6:0] BTC_IDX_CTRL0   = 7'h50;
  localparam logic [6:0] BTC_IDX_CTRL1   = 7'h51;
  localparam logic [6:0] BTC_IDX_LMODE   = 7'h52;
  localparam logic [6:0] BTC_IDX_LVIS    = 7'h53;
  localparam logic [6:0] BTC_IDX_SXL     = 7'h54;
  localparam logic [6:0] BTC_IDX_SXH     = 7'h55;
  localparam logic [6:0] BTC_IDX_SYL     = 7'h56;
  localparam logic [6:0] BTC_IDX_SYH     = 7'h57;
  localparam logic [6:0] BTC_IDX_DXL     = 7'h58;
  localparam logic [6:0] BTC_IDX_DXH     = 7'h59;
  localparam logic [6:0] BTC_IDX_DYL     = 7'h5a;
  localparam logic [6:0] BTC_IDX_DYH     = 7'h5b;
  localparam logic [6:0] BTC_IDX_WL      = 7'h5c;
  localparam logic [6:0] BTC_IDX_WH      = 7'h5d;
  localparam logic [6:0] BTC_IDX_HL      = 7'h5e;
  localparam logic [6:0] BTC_IDX_HH      = 7'h5f;

  // writable bits per entry, entry 15 first
  localparam logic [BTC_NREG-1:0][7:0] BTC_WMASK = {
    8'h03, 8'hff, 8'h03, 8'hff,
    8'h81, 8'hff, 8'h03, 8'hff,
    8'h81, 8'hff, 8'h03, 8'hff,
    8'hff, 8'he7, 8'hff, 8'h60};

  // reset value of every stored byte
  localparam logic [7:0] BTC_RST_BYTE = 8'h00;

  // field positions
  localparam int BTC_BIT_START   = 7;
  localparam int BTC_BIT_SRC_LIN = 6;
  localparam int BTC_BIT_DST_LIN = 5;
  localparam int BTC_BIT_FLOAT   = 5;
  localparam int BTC_BIT_LAYER   = 7;

  // axi responses
  localparam logic [1:0] BTC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BTC_RESP_SLVERR = 2'h2;

  // engine activity
  typedef enum logic {BTC_IDLE, BTC_BUSY} btc_eng_t;

  // decoded settings handed to the transfer datapath
  typedef struct packed {
    logic       src_linear;
    logic       dst_linear;
    logic [3:0] rop;
    logic [3:0] opcode;
    logic [1:0] scroll_mode;
    logic       float_transp;
    logic [2:0] disp_mode;
    logic [3:0] l2_vis;
    logic [3:0] l1_vis;
    logic [9:0] src_x;
    logic [8:0] src_y;
    logic       src_layer;
    logic [9:0] dst_x;
    logic [8:0] dst_y;
    logic       dst_layer;
    logic [9:0] width;
    logic [9:0] height;
  } btc_cfg_t;

  // complete state of the register bank
  typedef struct packed {
    logic [BTC_NREG-1:0][7:0] regs;
    btc_eng_t                 eng;
    logic                     start;
    logic                     aw_got;
    logic [BTC_IDX_W-1:0]     aw_idx;
    logic                     w_got;
    logic [7:0]               w_byte;
    logic                     w_lane;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [7:0]               rbyte;
    logic [1:0]               rresp;
  } btc_state_t;

endpackage

// [verif/btc_regs_props.sv]
// assertions on the block transfer control register bank ports
`timescale 1ns/10ps
module btc_regs_props (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  // register bus
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  // engine
  input wire logic        o_start,
  input wire logic        o_busy,
  input wire logic        i_done
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // answers stand until taken
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
  AST_W_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answering");
  AST_RD_ZERO: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // start is one pulse beside the write answer
  AST_START_ONE: assert property (o_start |=> !o_start)
    else $error("start pulse too long");
  AST_START_BUSY: assert property (o_start |-> o_busy && o_bvalid)
    else $error("start without busy");
  AST_BUSY_RISE: assert property ($rose(o_busy) |-> o_start)
    else $error("busy without start");
  AST_BUSY_HOLD: assert property (o_busy && !i_done |=> o_busy)
    else $error("busy dropped early");
  AST_BUSY_END: assert property (o_busy && i_done |=> !o_busy)
    else $error("busy stuck after done");
  // main scenarios
  cover property (o_start);
  cover property (o_busy && i_done);
  cover property (o_bvalid && o_bresp == 2'h2);
endmodule

bind btc_regs btc_regs_props i_btc_regs_props (.i_clock, .i_rst_n,
  .o_awready, .o_wready, .o_bvalid, .i_bready, .o_bresp, .o_rvalid,
  .i_rready, .o_rdata, .o_start, .o_busy, .i_done);

// [verif/test_btc_regs.sv]
// self-checking bench for the block transfer control register bank
`timescale 1ns/10ps
module test_btc_regs;
  // design ports
  logic              i_clock, i_rst_n, i_awvalid, i_wvalid, i_bready;
  logic              i_arvalid, i_rready, i_done, o_awready, o_wready;
  logic              o_bvalid, o_arready, o_rvalid, o_start, o_busy;
  logic [8:0]        i_awaddr, i_araddr;
  logic [2:0]        i_awprot, i_arprot;
  logic [31:0]       i_wdata, o_rdata;
  logic [3:0]        i_wstrb;
  logic [1:0]        o_bresp, o_rresp;
  btc_pkg::btc_cfg_t o_cfg;
  // model: stored bytes, writable masks, engine state
  logic [7:0]        r [16];
  logic [7:0]        mk [16] = '{8'h60, 8'hff, 8'he7, 8'hff, 8'hff, 8'h03,
    8'hff, 8'h81, 8'hff, 8'h03, 8'hff, 8'h81, 8'hff, 8'h03, 8'hff, 8'h03};
  logic              mbusy;
  int                fails, checks;
  logic [31:0]       seed;

  btc_regs i_btc_regs (.i_clock, .i_rst_n, .i_awvalid, .o_awready,
    .i_awaddr, .i_awprot, .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
    .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_start,
    .o_busy, .i_done, .o_cfg);

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [83:0] e,
                     input logic [83:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // one write; bready held high until bvalid seen
  task automatic wr(input int ix, input logic [7:0] d, input logic s = 1);
    logic       a, w, b, st, ok;
    logic [1:0] rs;
    ok = ix >= 'h50 && ix < 'h60;
    b = 0;
    @(posedge i_clock);
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    i_awaddr <= 9'(ix * 4);
    i_wdata <= {24'h0, d};
    i_wstrb <= {3'h0, s};
    // wait for the answer; only the watchdog ends a hang
    while (!b) begin
      @(negedge i_clock);
      a = i_awvalid && o_awready;
      w = i_wvalid && o_wready;
      b = o_bvalid;
      st = o_start;
      rs = o_bresp;
      @(posedge i_clock);
      if (a) i_awvalid <= 0;
      if (w) i_wvalid <= 0;
    end
    i_bready <= 0;
    chk("bresp", ok ? 2'h0 : 2'h2, rs);
    chk("start", ok && s && ix == 'h50 && d[7] && !mbusy, st);
    if (ok && s) r[ix - 'h50] = d & mk[ix - 'h50];
    if (ok && s && ix == 'h50 && d[7]) mbusy = 1;
  endtask

  // one read; rready held high until rvalid seen
  task automatic rd(input int ix);
    logic        a, b, ok;
    logic [7:0]  e;
    logic [31:0] d;
    logic [1:0]  rs;
    ok = ix >= 'h50 && ix < 'h60;
    e = ok ? r[ix - 'h50] : 8'h0;
    if (ix == 'h50) e[7] = mbusy;
    b = 0;
    @(posedge i_clock);
    i_arvalid <= 1;
    i_rready <= 1;
    i_araddr <= 9'(ix * 4);
    // wait for the answer; only the watchdog ends a hang
    while (!b) begin
      @(negedge i_clock);
      a = i_arvalid && o_arready;
      b = o_rvalid;
      d = o_rdata;
      rs = o_rresp;
      @(posedge i_clock);
      if (a) i_arvalid <= 0;
    end
    i_rready <= 0;
    chk("rdata", {24'h0, e}, d);
    chk("rresp", ok ? 2'h0 : 2'h2, rs);
  endtask

  // decoded settings against the model
  task automatic cfg();
    chk("cfg", {r[0][6:5], r[1], r[2][7:5], r[2][2:0], r[3], r[5][1:0],
      r[4], r[7][0], r[6], r[7][7], r[9][1:0], r[8], r[11][0], r[10],
      r[11][7], r[13][1:0], r[12], r[15][1:0], r[14]}, o_cfg);
  endtask

  // write, read back, check settings
  task automatic wrc(input int ix, input logic [7:0] d);
    wr(ix, d);
    rd(ix);
    cfg();
  endtask

  // datapath reports the last pixel
  task automatic fin();
    @(posedge i_clock);
    i_done <= 1;
    @(posedge i_clock);
    i_done <= 0;
    mbusy = 0;
    @(negedge i_clock);
    chk("busy", 0, o_busy);
  endtask

  // verdict and stop
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    i_clock = 0;
    forever #10 i_clock = ~i_clock;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    end_of_test();
  end

  // main sequence
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_done} = '0;
    {i_awaddr, i_araddr, i_awprot, i_arprot, i_wdata, i_wstrb} = '0;
    {mbusy, fails, checks, i_rst_n} = '0;
    seed = 91702;
    foreach (r[j]) r[j] = 8'h0;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1;
    for (int j = 'h50; j < 'h60; j++) rd(j);
    cfg();
    $display("test reset done");
    for (int j = 0; j < 16; j++) begin
      wrc('h51, 8'(j * 17));
      // host clears the scroll bit elsewhere before buffer scroll
      if (j == 12) wr('h40, 8'h00);
      wrc('h52, 8'(j * 17));
      wrc('h53, 8'(j * 17));
    end
    $display("test codes done");
    for (int j = 0; j < 48; j++)
      wrc('h51 + j % 15, 8'(rnd()));
    $display("test random done");
    wrc('h50, 8'h7f);
    wrc('h50, 8'he0);
    chk("busy", 1, o_busy);
    wrc('h50, 8'h80);
    wrc('h5a, 8'h3c);
    fin();
    rd('h50);
    wr('h50, 8'h00);
    fin();
    wrc('h50, 8'ha0);
    fin();
    $display("test engine done");
    foreach (mk[j]) begin
      wr(j == 0 ? 'h4f : 'h60 + j * 7, 8'hff);
      rd(j == 0 ? 'h4f : 'h60 + j * 7);
    end
    wr('h54, 8'h5a, 0);
    rd('h54);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
